// file: rtl/axis_sync_position_controller.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
module axis_sync_position_controller
    import axis_sync_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    input  wire logic               enableIn,
    input  wire logic               startIn,
    input  wire logic               syncSelectInput,
    input  wire logic               sensorError,
    input  wire axis_in_t           axisIn,
    input  wire logic [3:0]         regAddr,
    input  wire logic [15:0]        regWdata,
    input  wire logic               regWrite,
    input  wire logic               regRead,
    output logic [15:0]             regRdata,
    output logic signed [OUT_W-1:0] valveOut,
    output logic                    readyOut,
    output logic                    statusOut,
    output logic                    sampleTick
);

    // configuration registers, addr[3] selects bank
    logic [15:0] ctrl_q, ctrl_d, brake_q, brake_d, win_q, win_d;
    logic [15:0] speed_q, speed_d, fault_q, fault_d;
    logic [15:0] emerg_q, emerg_d, deadb_q, deadb_d;
    logic [15:0] rdata_q, rdata_d;
    ctrl_t       cfg;
    assign cfg = ctrl_t'(ctrl_q[5:0]);

    // control state
    axis_state_t      state_q, state_d;
    logic [19:0]      tick_q, tick_d;
    logic [POS_W-1:0] target_q, target_d;
    logic [POS_W-1:0] profile_q, profile_d;
    logic signed [OUT_W-1:0] out_q, out_d;
    logic             status_q, status_d;
    logic             ready_q, ready_d;
    logic             enable_q, start_q;

    // working terms
    logic signed [POS_W:0]   err;
    logic [POS_W-1:0]        absErr, refPos, stepLim, lead;
    logic [31:0]             gainNum, gain;
    logic signed [47:0]      prod;
    logic signed [47:0]      shaped;
    logic                    tickNow, syncActive, inWindow;

    assign tickNow = (tick_q == 20'(TICK_CYC - 1));

    // register file next values and read mux
    always_comb begin
        ctrl_d  = ctrl_q;
        brake_d = brake_q;
        win_d   = win_q;
        speed_d = speed_q;
        fault_d = fault_q;
        emerg_d = emerg_q;
        deadb_d = deadb_q;
        rdata_d = 16'h0000;
        if (regWrite) begin
            unique case ({regAddr[3], regAddr[1:0]})
                {1'b0, REG_CTRL}:   ctrl_d  = regWdata;
                {1'b0, REG_BRAKE}:  brake_d = regWdata;
                {1'b0, REG_WIN}:    win_d   = regWdata;
                {1'b1, REG_SPEED}:  speed_d = regWdata;
                {1'b1, REG_FAULT}:  fault_d = regWdata;
                {1'b1, REG_EMERG}:  emerg_d = regWdata;
                {1'b1, REG_DEADB}:  deadb_d = regWdata;
                default:            ;
            endcase
        end
        if (regRead) begin
            unique case ({regAddr[3], regAddr[1:0]})
                {1'b0, REG_CTRL}:   rdata_d = ctrl_q;
                {1'b0, REG_BRAKE}:  rdata_d = brake_q;
                {1'b0, REG_WIN}:    rdata_d = win_q;
                {1'b0, REG_STATUS}: rdata_d = {11'h000, state_q, syncActive,
                                               ready_q, status_q};
                {1'b1, REG_SPEED}:  rdata_d = speed_q;
                {1'b1, REG_FAULT}:  rdata_d = fault_q;
                {1'b1, REG_EMERG}:  rdata_d = emerg_q;
                {1'b1, REG_DEADB}:  rdata_d = deadb_q;
                default:            rdata_d = 16'h0000;
            endcase
        end
        if (regAddr[2]) begin
            rdata_d = 16'h0000;          // unmapped upper slots
            if (regWrite) begin
                ctrl_d  = ctrl_q;
                brake_d = brake_q;
                win_d   = win_q;
                speed_d = speed_q;
                fault_d = fault_q;
                emerg_d = emerg_q;
                deadb_d = deadb_q;
            end
        end
    end

    // register file flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q  <= CTRL_RST;
            brake_q <= BRAKE_RST;
            win_q   <= WIN_RST;
            speed_q <= SPEED_RST;
            fault_q <= 16'h0000;
            emerg_q <= EMERG_RST;
            deadb_q <= DEADB_RST;
            rdata_q <= 16'h0000;
        end else begin
            ctrl_q  <= ctrl_d;
            brake_q <= brake_d;
            win_q   <= win_d;
            speed_q <= speed_d;
            fault_q <= fault_d;
            emerg_q <= emerg_d;
            deadb_q <= deadb_d;
            rdata_q <= rdata_d;
        end
    end

    // reference selection and error
    always_comb begin
        // master/master crosswise or slave following master
        syncActive = syncSelectInput || cfg.slaveRole;
        // inactive select and no slave role: own target
        refPos = syncActive ? axisIn.partnerPos : target_q;
        if (cfg.profileMode && !syncActive) begin
            refPos = profile_q;
        end
        err    = $signed({1'b0, refPos}) - $signed({1'b0, axisIn.actPos});
        absErr = err[POS_W] ? POS_W'(-err) : err[POS_W-1:0];
        inWindow = (absErr <= win_q);
        // speed limit source
        stepLim = cfg.speedExternal ? axisIn.speedDemand : speed_q;
        unique case (curve_t'(cfg.curve))
            CURVE_ROOT1: gainNum = GAIN_ROOT1;
            CURVE_ROOT2: gainNum = GAIN_ROOT2;
            default:     gainNum = GAIN_LIN;
        endcase
        // shorter braking distance, higher gain
        gain = gainNum / ((brake_q == 16'h0000) ? 32'd1 : {16'h0000, brake_q});
        // stroke dependent: gain scales with remaining stroke
        if (!cfg.profileMode && absErr < brake_q) begin
            gain = gain * {16'h0000, absErr} / {16'h0000, brake_q};
        end
        // double gain inside deadband
        if (absErr < deadb_q) begin
            gain = gain << 1;
        end
        prod = 48'(signed'(err)) * $signed({16'h0000, gain});
        shaped = prod;
        // saturate to full scale
        if (shaped > 48'(OUT_FS)) begin
            shaped = 48'(OUT_FS);
        end else if (shaped < 48'(OUT_NFS)) begin
            shaped = 48'(OUT_NFS);
        end
        lead = POS_W'(absErr > stepLim ? stepLim : absErr);
    end

    // sequencing state next values
    always_comb begin
        tick_d    = tickNow ? 20'h00000 : tick_q + 20'h00001;
        state_d   = state_q;
        target_d  = target_q;
        profile_d = profile_q;
        out_d     = out_q;
        status_d  = status_q;
        ready_d   = enableIn && !sensorError;
        if (!enableIn) begin
            state_d = ST_OFF;
        end else if (state_q == ST_OFF) begin
            state_d  = ST_HOLD;
            target_d = axisIn.actPos;
            profile_d = axisIn.actPos;
        end else if (startIn && !start_q) begin
            state_d  = ST_RUN;
            target_d = axisIn.cmdPos;
        end else if (!startIn && start_q && state_q == ST_RUN) begin
            state_d  = ST_HOLD;
            target_d = err[POS_W] ? axisIn.actPos - emerg_q
                                  : axisIn.actPos + emerg_q;
            profile_d = target_d;
        end
        if (tickNow) begin
            // moving profile steps toward target at limited speed
            if (profile_q < target_q) begin
                profile_d = profile_q + ((target_q - profile_q) > stepLim
                                         ? stepLim : target_q - profile_q);
            end else begin
                profile_d = profile_q - ((profile_q - target_q) > stepLim
                                         ? stepLim : profile_q - target_q);
            end
            // sync correction overrides positioning
            out_d = OUT_W'(shaped);
            if (!syncActive && lead == 16'h0000) begin
                out_d = 16'sh0000;
            end
            // status meaning follows sync select
            status_d = startIn && inWindow;
        end
        if (!startIn) begin
            status_d = 1'b0;
        end
        if (state_q == ST_OFF) begin
            out_d = 16'sh0000;
        end
        // fault override
        if (cfg.faultOverrideEn && (sensorError || !enableIn)) begin
            out_d = signed'(fault_q);
        end
    end

    // sequencing flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q   <= ST_OFF;
            tick_q    <= 20'h00000;
            target_q  <= 16'h0000;
            profile_q <= 16'h0000;
            out_q     <= 16'sh0000;
            status_q  <= 1'b0;
            ready_q   <= 1'b0;
            enable_q  <= 1'b0;
            start_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            tick_q    <= tick_d;
            target_q  <= target_d;
            profile_q <= profile_d;
            out_q     <= out_d;
            status_q  <= status_d;
            ready_q   <= ready_d;
            enable_q  <= enableIn;
            start_q   <= startIn;
        end
    end

    assign regRdata   = rdata_q;
    assign valveOut   = out_q;
    assign readyOut   = ready_q;
    assign statusOut  = status_q;
    assign sampleTick = tickNow;

    // assertions
    ready_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        1'b1 |=> readyOut == $past(enableIn && !sensorError))
        else $error("ready does not follow enable and sensor state");

    status_start_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !startIn |=> !statusOut)
        else $error("status high without start");

    tick_period_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tickNow |=> !tickNow [*8])
        else $error("sample tick repeats too soon");

    hold_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (enableIn && state_q == ST_OFF) |=> target_q == $past(axisIn.actPos))
        else $error("target not loaded on enable");

    start_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (enableIn && state_q != ST_OFF && startIn && !start_q)
        |=> target_q == $past(axisIn.cmdPos))
        else $error("command not captured on start");

    fault_force_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (cfg.faultOverrideEn && sensorError) |=> valveOut == $past(fault_q))
        else $error("fault value not forced");

    out_sat_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        valveOut >= OUT_NFS)
        else $error("output beyond negative full scale");

    status_win_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (tickNow && startIn) |=> statusOut == $past(inWindow))
        else $error("status does not match window");

    // state is off whenever enable was low last cycle
    enable_off_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !enable_q |-> state_q == ST_OFF)
        else $error("axis active without enable");

    enable_hold_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (enableIn && state_q == ST_OFF) |=> state_q == ST_HOLD)
        else $error("axis does not hold after enable");

    disable_off_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !enableIn |=> state_q == ST_OFF)
        else $error("axis not off after enable removed");

    off_output_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (state_q == ST_OFF && !cfg.faultOverrideEn) |=> valveOut == 16'sh0000)
        else $error("output not idle while off");

    fault_enable_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (cfg.faultOverrideEn && !enableIn) |=> valveOut == $past(fault_q))
        else $error("fault value not forced on enable loss");

    start_run_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (enableIn && state_q != ST_OFF && startIn && !start_q)
        |=> state_q == ST_RUN)
        else $error("start does not begin a move");

    // start dropped mid-move: stop one emergency stroke further on
    emerg_load_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (enableIn && state_q == ST_RUN && !startIn && start_q)
        |=> target_q == ($past(err[POS_W])
                         ? $past(axisIn.actPos) - $past(emerg_q)
                         : $past(axisIn.actPos) + $past(emerg_q)))
        else $error("emergency target wrong");

    emerg_hold_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (enableIn && state_q == ST_RUN && !startIn && start_q)
        |=> state_q == ST_HOLD)
        else $error("axis keeps running after start removed");

    // reference selection per synchronisation mode
    ref_sync_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        syncSelectInput |-> refPos == axisIn.partnerPos)
        else $error("synchronised axis not using partner position");

    ref_slave_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        cfg.slaveRole |-> refPos == axisIn.partnerPos)
        else $error("slave not following master position");

    ref_own_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (!syncActive && !cfg.profileMode) |-> refPos == target_q)
        else $error("independent axis not using own target");

    ref_profile_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (!syncActive && cfg.profileMode) |-> refPos == profile_q)
        else $error("profile mode not using moving profile");

    // between samples the output only moves on off or fault
    out_hold_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (!tickNow && state_q != ST_OFF
         && !(cfg.faultOverrideEn && (sensorError || !enableIn)))
        |=> $stable(valveOut))
        else $error("output changed between samples");

    status_hold_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (!tickNow && startIn) |=> $stable(statusOut))
        else $error("status changed between samples");

    tick_count_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        tick_q <= 20'(TICK_CYC - 1))
        else $error("sample counter out of range");

    sat_range_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        shaped <= 48'(OUT_FS) && shaped >= 48'(OUT_NFS))
        else $error("command not saturated");

    sync_status_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (tickNow && startIn && syncActive)
        |=> statusOut == $past(absErr <= win_q))
        else $error("status does not report sync error");

    ready_fault_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        sensorError |=> !readyOut)
        else $error("ready high with sensor error");

    ready_enable_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (enableIn && !sensorError) |=> readyOut)
        else $error("ready low although axis is ready");

    // read data stands only in the cycle after a read
    rdata_idle_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !regRead |=> regRdata == 16'h0000)
        else $error("read data without read strobe");

    rdata_gap_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (regRead && regAddr[2]) |=> regRdata == 16'h0000)
        else $error("unmapped slot returned data");

endmodule // axis_sync_position_controller

// file: rtl/axis_sync_pkg.sv
package axis_sync_pkg;

    localparam int POS_W = 16;
    localparam int OUT_W = 16;

    localparam logic [31:0] SAMPLE_NS  = 32'd1000000;
    localparam logic [31:0] CLK_NS     = 32'd10;
    localparam int          TICK_CYC   = int'(SAMPLE_NS / CLK_NS);

    localparam logic signed [OUT_W-1:0] OUT_FS  = 16'sh7FFF;
    localparam logic signed [OUT_W-1:0] OUT_NFS = -16'sh7FFF;

    localparam logic [31:0] GAIN_LIN   = 32'd10000;
    localparam logic [31:0] GAIN_ROOT1 = 32'd30000;
    localparam logic [31:0] GAIN_ROOT2 = 32'd50000;

    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_BRAKE  = 2'h1;
    localparam logic [1:0] REG_WIN    = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;
    localparam logic [1:0] REG_SPEED  = 2'h0;
    localparam logic [1:0] REG_FAULT  = 2'h1;
    localparam logic [1:0] REG_EMERG  = 2'h2;
    localparam logic [1:0] REG_DEADB  = 2'h3;

    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] BRAKE_RST = 16'h0100;
    localparam logic [15:0] WIN_RST   = 16'h0010;
    localparam logic [15:0] SPEED_RST = 16'h7FFF;
    localparam logic [15:0] EMERG_RST = 16'h0020;
    localparam logic [15:0] DEADB_RST = 16'h0000;

    typedef enum logic [1:0] {
        CURVE_LIN   = 2'b00,
        CURVE_ROOT1 = 2'b01,
        CURVE_ROOT2 = 2'b10
    } curve_t;

    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b10
    } axis_state_t;

    typedef struct packed {
        logic       faultOverrideEn;
        logic       speedExternal;
        logic       profileMode;
        logic       slaveRole;
        logic [1:0] curve;
    } ctrl_t;

    typedef struct packed {
        logic [POS_W-1:0] cmdPos;
        logic [POS_W-1:0] actPos;
        logic [POS_W-1:0] partnerPos;
        logic [POS_W-1:0] speedDemand;
    } axis_in_t;

endpackage

// file: bench/axis_valve_model.sv
`timescale 1ns/1ps
module axis_valve_model
    import axis_sync_pkg::*;
#(
    parameter logic [POS_W-1:0] START_POS = 16'h0000
)
(
    input  wire logic                    clk_sys,
    input  wire logic                    arst_n,
    input  wire logic                    sampleTick,
    input  wire logic signed [OUT_W-1:0] valveOut,
    input  wire logic [POS_W-1:0]        cmdPos,
    output axis_in_t                     axisIn
);
    logic [POS_W-1:0] actPos_q;
    logic [POS_W-1:0] actPos_d;

    // cylinder moves by valve flow once per sample
    always_comb begin
        actPos_d = actPos_q;
        if (sampleTick) begin
            actPos_d = actPos_q + POS_W'(valveOut >>> 10);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            actPos_q <= START_POS;
        end else begin
            actPos_q <= actPos_d;
        end
    end

    // partner axis lags slightly; external speed demand wide open
    assign axisIn = '{cmdPos: cmdPos, actPos: actPos_q,
                      partnerPos: actPos_q - 16'h0004,
                      speedDemand: 16'h7FFF};
endmodule // axis_valve_model

// file: bench/axis_sync_position_controller_tb_top.sv
`timescale 1ns/1ps
module axis_sync_position_controller_tb_top
    import axis_sync_pkg::*;
;
    logic                    clk_sys;
    logic                    arst_n;
    logic                    enableIn;
    logic                    startIn;
    logic                    syncSelectInput;
    logic                    sensorError;
    logic [POS_W-1:0]        cmdPos;
    axis_in_t                axisIn;
    logic [3:0]              regAddr;
    logic [15:0]             regWdata;
    logic                    regWrite;
    logic                    regRead;
    logic [15:0]             regRdata;
    logic signed [OUT_W-1:0] valveOut;
    logic                    readyOut;
    logic                    statusOut;
    logic                    sampleTick;
    int                      fail_count;
    int                      tests_run;
    logic [15:0]             rd;
    logic [15:0]             fv;
    logic                    pe;
    logic                    ps;

    axis_sync_position_controller u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .enableIn(enableIn),
        .startIn(startIn), .syncSelectInput(syncSelectInput),
        .sensorError(sensorError), .axisIn(axisIn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .valveOut(valveOut), .readyOut(readyOut),
        .statusOut(statusOut), .sampleTick(sampleTick));

    axis_valve_model u_model (
        .clk_sys(clk_sys), .arst_n(arst_n), .sampleTick(sampleTick),
        .valveOut(valveOut), .cmdPos(cmdPos), .axisIn(axisIn));

    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // word and flag comparisons
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpBit(input logic got, input logic exp);
        cmp16({15'h0, got}, {15'h0, exp});
    endtask

    // register bus cycles
    task automatic regWr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic regRd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask

    // saturated product of error and gain
    function automatic logic [15:0] satOut(longint e, longint g);
        longint v;
        v = e * g;
        if (v > 32767) v = 32767;
        if (v < -32767) v = -32767;
        return 16'(v);
    endfunction

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        fail_count = 0;
        tests_run = 0;
        arst_n = 1'b0;
        {enableIn, startIn, syncSelectInput, sensorError} = 4'h0;
        {regWrite, regRead, regAddr, regWdata} = '0;
        cmdPos = 16'h0000;
        rd = 16'($urandom(51299));
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1 cmpBit(readyOut, 1'b0);
        // reset values, unmapped place, read-back
        regRd(4'h1, rd); cmp16(rd, BRAKE_RST);
        regRd(4'h2, rd); cmp16(rd, WIN_RST);
        regRd(4'h8, rd); cmp16(rd, SPEED_RST);
        regRd(4'hA, rd); cmp16(rd, EMERG_RST);
        regWr(4'h4, 16'hFFFF);
        regRd(4'h4, rd); cmp16(rd, 16'h0000);
        fv = 16'($urandom_range(1, 16'h7FFE));
        regWr(4'h9, fv);
        regRd(4'h9, rd); cmp16(rd, fv);
        $display("test registers done");
        // ready follows enable and sensor state
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            enableIn <= 1'($urandom);
            sensorError <= 1'($urandom);
            syncSelectInput <= 1'($urandom);
            pe = enableIn;
            ps = sensorError;
            #1 cmpBit(readyOut, pe && !ps);
            cmpBit(statusOut, 1'b0);
        end
        $display("test ready done");
        // fault override on sensor fault and on enable loss
        regWr(4'h0, 16'h0020);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            enableIn <= 1'b1;
            sensorError <= 1'b0;
            repeat (3) @(posedge clk_sys);
            if (k == 0) sensorError <= 1'b1;
            else enableIn <= 1'b0;
            @(posedge clk_sys);
            #1 cmp16(valveOut, fv);
        end
        $display("test fault done");
        // move toward far command: first sample saturates output
        regWr(4'h0, 16'h0000);
        regWr(4'h1, 16'h0001);
        @(posedge clk_sys);
        {syncSelectInput, sensorError} <= 2'b00;
        enableIn <= 1'b1;
        cmdPos <= 16'hF000 | 16'($urandom_range(0, 16'h0FFF));
        repeat (4) @(posedge clk_sys);
        startIn <= 1'b1;
        begin : waitTick
            for (int n = 0; n < 100100; n++) begin
                @(posedge clk_sys);
                #1 if (sampleTick === 1'b1) disable waitTick;
            end
            fail_count++;
            test_done();
        end
        @(posedge clk_sys);
        #1 cmpBit(sampleTick, 1'b0);
        cmp16(valveOut, satOut(longint'(cmdPos), 10000));
        @(posedge clk_sys);
        startIn <= 1'b0;
        @(posedge clk_sys);
        #1 cmpBit(statusOut, 1'b0);
        $display("test motion done");
        test_done();
    end
endmodule // axis_sync_position_controller_tb_top
